// ===== logic/sdli_pkg.sv
// Shared constants and types for the serial DAC load interface
package sdli_pkg;
   // Channel and word geometry
   localparam int CH_N   = 4;
   localparam int CH_AW  = 2;
   localparam int CODE_W = 10;
   localparam int WORD_W = 16;
   localparam int CNT_W  = 4;

   // Command word fields
   localparam int CMD_HI  = 15;
   localparam int CMD_LO  = 14;
   localparam int ADDR_HI = 13;
   localparam int ADDR_LO = 12;
   localparam int VAL_HI  = 9;
   localparam int VAL_LO  = 0;

   // Command codes
   localparam logic [1:0] CMD_DATA = 2'h0;
   localparam logic [1:0] CMD_CTRL = 2'h1;
   localparam logic [1:0] CMD_SUB  = 2'h2;

   // Channel control bits inside the value field
   localparam int CTRL_REF_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;

   // Bit counter value of the sixteenth bit
   localparam logic [CNT_W-1:0] BIT_LAST = 4'hf;

   // Reset and clear values
   localparam logic [CODE_W-1:0] CODE_MID      = 10'h200;
   localparam logic [CODE_W-1:0] DAC_RST       = 10'h200;
   localparam logic [CODE_W-1:0] DATA_RST      = 10'h200;
   localparam logic [CODE_W-1:0] SUB_RST       = 10'h000;
   localparam logic [CODE_W-1:0] BIAS_INT_CODE = 10'h200;
   localparam logic [1:0]        SYNC_IDLE_HI  = 2'h3;

   // Frame state
   typedef enum logic [1:0] {SDLI_IDLE, SDLI_SHIFT, SDLI_DONE} sdli_frame_t;
endpackage

// ===== logic/sdli_chan_mem.sv
// Channel data registers, written one word at a time, read all at once
`timescale 1ns/1ps
module sdli_chan_mem
   import sdli_pkg::*;
(
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // Write port
   input  wire logic                           wr_en,
   input  wire logic [CH_AW-1:0]               wr_addr,
   input  wire logic [CODE_W-1:0]              wr_data,
   // Read port, all channels in parallel
   output logic      [CH_N-1:0][CODE_W-1:0]    rd_data
);
   typedef struct packed {
      logic [CH_N-1:0][CODE_W-1:0] word;
   } sdli_mem_st_t;

   sdli_mem_st_t r;
   sdli_mem_st_t next_r;

   always_comb
   begin
      next_r = r;
      if (wr_en)
      begin
         next_r.word[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r <= {CH_N{DATA_RST}};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign rd_data = r.word;

   property p_word_stored;
      @(posedge clk) disable iff (!rst_b)
      wr_en |=> (rd_data[$past(wr_addr)] == $past(wr_data));
   endproperty
   a_word_stored: assert property (p_word_stored) // [R08]
      else $error("decoded data word not stored in its channel");
endmodule // sdli_chan_mem

// ===== logic/sdli_top.sv
// Serial load interface: frame capture, decode, load, clear and power-down
`timescale 1ns/1ps
// Functional notes
// R01 - Low frame sync enables the shift register; bits taken on serial clock falls.
// R02 - One transfer is a sixteen-bit word sampled on falling serial clock edges.
// R03 - Low load strobe copies all data registers into DAC registers together.
// R04 - Load strobe low at the sixteenth fall updates outputs automatically.
// R05 - Clear sets main DACs to bias or bias/16 and resets every sub DAC.
// R06 - Low power-down input enters low power; high input leaves it.
// R07 - A channel selecting the external reference is centred on that reference.
// R08 - Sixteen bits of one frame form one command; partial frames are dropped.
module sdli_top
   import sdli_pkg::*;
(
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // Serial link pins
   input  wire logic                           serial_clock_in,
   input  wire logic                           serial_data_in,
   input  wire logic                           frame_sync_n,
   // Control pins
   input  wire logic                           load_outputs_n,
   input  wire logic                           async_clear_n,
   input  wire logic                           power_down_n,
   // External reference, as a code
   input  wire logic [CODE_W-1:0]              external_reference_in,
   // Channel outputs
   output logic      [CH_N-1:0][CODE_W-1:0]    dac_code,
   output logic      [CH_N-1:0][CODE_W-1:0]    sub_code,
   output logic      [CH_N-1:0][CODE_W-1:0]    bias_code,
   output logic      [CH_N-1:0]                bias_div16,
   // Status
   output logic                                low_power
);
   typedef struct packed {
      logic [1:0]                     sck_sy;
      logic [1:0]                     sdi_sy;
      logic [1:0]                     fs_sy;
      logic [1:0]                     ld_sy;
      logic [1:0]                     clr_sy;
      logic [1:0]                     pd_sy;
      logic [CODE_W-1:0]              ext_sy0;
      logic [CODE_W-1:0]              ext_sy1;
      logic                           sck_prev;
      logic [WORD_W-1:0]              shift;
      logic [CNT_W-1:0]               bit_cnt;
      sdli_frame_t                    state;
      logic                           auto_pend;
      logic [CH_N-1:0][CODE_W-1:0]    dac;
      logic [CH_N-1:0][CODE_W-1:0]    sub;
      logic [CH_N-1:0][CODE_W-1:0]    bias;
      logic [CH_N-1:0]                ref_sel;
      logic [CH_N-1:0]                clr_mode;
      logic [CH_N-1:0]                div16;
      logic                           low_power;
   } sdli_st_t;

   sdli_st_t                    r;
   sdli_st_t                    next_r;
   logic                        sck_fall;
   logic                        fire;
   logic [WORD_W-1:0]           new_word;
   logic                        mem_wr_en;
   logic [CH_N-1:0][CODE_W-1:0] mem_rd;

   // Two-stage synchroniser step; stage 0 feeds only stage 1
   function automatic logic [1:0] sdli_sync2(input logic [1:0] s, input logic d);
      return {s[0], d};
   endfunction

   // Synchronised levels, all from the second stage
   logic fs_s;
   logic ld_s;
   logic clr_s;
   logic pd_s;
   assign fs_s  = r.fs_sy[1];
   assign ld_s  = r.ld_sy[1];
   assign clr_s = r.clr_sy[1];
   assign pd_s  = r.pd_sy[1];

   always_comb
   begin
      next_r          = r;
      next_r.sck_sy   = sdli_sync2(r.sck_sy, serial_clock_in);
      next_r.sdi_sy   = sdli_sync2(r.sdi_sy, serial_data_in);
      next_r.fs_sy    = sdli_sync2(r.fs_sy, frame_sync_n);
      next_r.ld_sy    = sdli_sync2(r.ld_sy, load_outputs_n);
      next_r.clr_sy   = sdli_sync2(r.clr_sy, async_clear_n);
      next_r.pd_sy    = sdli_sync2(r.pd_sy, power_down_n);
      next_r.ext_sy0  = external_reference_in;
      next_r.ext_sy1  = r.ext_sy0;
      next_r.sck_prev = r.sck_sy[1];
      // Data pin has the same latency as the clock pin, so it lines up with the edge
      sck_fall  = r.sck_prev & ~r.sck_sy[1];
      new_word  = {r.shift[WORD_W-2:0], r.sdi_sy[1]};
      fire      = 1'b0;
      mem_wr_en = 1'b0;

      case (r.state)
         SDLI_IDLE, SDLI_SHIFT:
         begin
            if (fs_s)
            begin
               // Frame ended early: partial word is dropped
               next_r.state   = SDLI_IDLE; // [R08]
               next_r.bit_cnt = '0;
            end
            else
            begin
               next_r.state = SDLI_SHIFT; // [R01]
               if (sck_fall)
               begin
                  next_r.shift = new_word; // [R02]
                  if (r.bit_cnt == BIT_LAST)
                  begin
                     fire         = 1'b1; // [R08]
                     next_r.state = SDLI_DONE;
                  end
                  else
                  begin
                     next_r.bit_cnt = r.bit_cnt + 4'h1; // [R01]
                  end
               end
            end
         end
         SDLI_DONE:
         begin
            // Extra bits past sixteen are ignored until the frame closes
            if (fs_s)
            begin
               next_r.state   = SDLI_IDLE;
               next_r.bit_cnt = '0;
            end
         end
         default:
         begin
            next_r.state   = SDLI_IDLE;
            next_r.bit_cnt = '0;
         end
      endcase

      if (fire)
      begin
         case (new_word[CMD_HI:CMD_LO])
            CMD_DATA:
            begin
               mem_wr_en = 1'b1; // [R08]
            end
            CMD_CTRL:
            begin
               next_r.ref_sel[new_word[ADDR_HI:ADDR_LO]]  = new_word[CTRL_REF_BIT];
               next_r.clr_mode[new_word[ADDR_HI:ADDR_LO]] = new_word[CTRL_CLR_BIT];
            end
            CMD_SUB:
            begin
               next_r.sub[new_word[ADDR_HI:ADDR_LO]] = new_word[VAL_HI:VAL_LO];
            end
            default:
            begin
               next_r.auto_pend = r.auto_pend;
            end
         endcase
      end

      // Update waits one cycle so the word just decoded is included
      next_r.auto_pend = fire & ~ld_s; // [R04]
      if (!ld_s || r.auto_pend)
      begin
         next_r.dac   = mem_rd; // [R03] [R04]
         next_r.div16 = '0;
      end
      // Clear overrides any load in the same cycle
      if (!clr_s)
      begin
         next_r.dac   = {CH_N{CODE_MID}}; // [R05]
         next_r.sub   = {CH_N{SUB_RST}};
         next_r.div16 = r.clr_mode;
      end

      for (int i = 0; i < CH_N; i++)
      begin
         next_r.bias[i] = r.ref_sel[i] ? r.ext_sy1 : BIAS_INT_CODE; // [R07]
      end
      next_r.low_power = ~pd_s; // [R06]
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r        <= '0;
         r.fs_sy  <= SYNC_IDLE_HI;
         r.ld_sy  <= SYNC_IDLE_HI;
         r.clr_sy <= SYNC_IDLE_HI;
         r.pd_sy  <= SYNC_IDLE_HI;
         r.dac    <= {CH_N{DAC_RST}};
         r.sub    <= {CH_N{SUB_RST}};
         r.bias   <= {CH_N{BIAS_INT_CODE}};
         r.state  <= SDLI_IDLE;
      end
      else
      begin
         r <= next_r;
      end
   end

   sdli_chan_mem sdli_chan_mem_i (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (mem_wr_en),
      .wr_addr (new_word[ADDR_HI:ADDR_LO]),
      .wr_data (new_word[VAL_HI:VAL_LO]),
      .rd_data (mem_rd)
   );

   assign dac_code   = r.dac;
   assign sub_code   = r.sub;
   assign bias_code  = r.bias;
   assign bias_div16 = r.div16;
   assign low_power  = r.low_power;

   sequence s_bit_in_frame;
      sck_fall && !fs_s && (r.state != SDLI_DONE) && (r.bit_cnt != BIT_LAST);
   endsequence
   sequence s_word_end_load;
      fire && !ld_s && clr_s && (new_word[CMD_HI:CMD_LO] == CMD_DATA);
   endsequence

   property p_bit_counted;
      @(posedge clk) disable iff (!rst_b)
      s_bit_in_frame |=> (r.bit_cnt == $past(r.bit_cnt) + 4'h1);
   endproperty
   a_bit_counted: assert property (p_bit_counted) // [R01]
      else $error("bit not counted during frame");

   property p_bit_sampled;
      @(posedge clk) disable iff (!rst_b)
      (sck_fall && !fs_s && r.state != SDLI_DONE) |=> (r.shift[0] == $past(r.sdi_sy[1]));
   endproperty
   a_bit_sampled: assert property (p_bit_sampled) // [R02]
      else $error("serial bit not shifted in on falling edge");

   property p_load_copies;
      @(posedge clk) disable iff (!rst_b)
      (!ld_s && clr_s) |=> (dac_code == $past(mem_rd));
   endproperty
   a_load_copies: assert property (p_load_copies) // [R03]
      else $error("load strobe did not copy all channels");

   property p_auto_update;
      @(posedge clk) disable iff (!rst_b)
      s_word_end_load ##1 clr_s |=>
         (dac_code[$past(new_word[ADDR_HI:ADDR_LO], 2)] == $past(new_word[VAL_HI:VAL_LO], 2));
   endproperty
   a_auto_update: assert property (p_auto_update) // [R04]
      else $error("automatic update at word end missing");

   property p_clear;
      @(posedge clk) disable iff (!rst_b)
      !clr_s |=> (dac_code == {CH_N{CODE_MID}}) && (sub_code == {CH_N{SUB_RST}})
                 && (bias_div16 == $past(r.clr_mode));
   endproperty
   a_clear: assert property (p_clear) // [R05]
      else $error("clear did not reset main and sub DACs");

   property p_power_down;
      @(posedge clk) disable iff (!rst_b)
      low_power == !$past(pd_s);
   endproperty
   a_power_down: assert property (p_power_down) // [R06]
      else $error("low power state does not follow the power-down input");

   property p_ext_ref;
      @(posedge clk) disable iff (!rst_b)
      r.ref_sel[3] |=> (bias_code[3] == $past(r.ext_sy1));
   endproperty
   a_ext_ref: assert property (p_ext_ref) // [R07]
      else $error("channel 3 not centred on external reference");

   property p_no_partial;
      @(posedge clk) disable iff (!rst_b)
      mem_wr_en |-> (r.bit_cnt == BIT_LAST) && !fs_s && sck_fall && (r.state == SDLI_SHIFT);
   endproperty
   a_no_partial: assert property (p_no_partial) // [R08]
      else $error("register written without a full sixteen-bit frame");
endmodule // sdli_top

// ===== test/sdli_host_model.sv
// Host side model: frames and shifts words onto the serial link
`timescale 1ns/1ps
module sdli_host_model
(
   // Serial link
   output logic serial_clock_in,
   output logic serial_data_in,
   output logic frame_sync_n
);
   initial
   begin
      serial_clock_in = 1'b1;
      serial_data_in  = 1'b0;
      frame_sync_n    = 1'b1;
   end

   // Clock idles high and stands still between frames; data turns over once released
   task automatic send_word(input logic [15:0] word, input int nbits, input logic framed);
      // Whole clock periods keep every pin change on a falling system clock edge
      #100;
      frame_sync_n = !framed;
      #400;
      for (int i = 15; i > 15 - nbits; i--)
      begin
         serial_data_in  = word[i];
         serial_clock_in = 1'b1;
         #400;
         serial_clock_in = 1'b0;
         #400;
      end
      serial_clock_in = 1'b1;
      serial_data_in  = ~serial_data_in;
      #400;
      frame_sync_n = 1'b1;
      #400;
   endtask
endmodule // sdli_host_model

// ===== test/sdli_top_tb.sv
// Self-checking testbench for the serial DAC load interface
`timescale 1ns/1ps
module sdli_top_tb
   import sdli_pkg::*;
;
   logic                        clk, rst_b, load_outputs_n, async_clear_n, power_down_n, low_power;
   logic                        serial_clock_in, serial_data_in, frame_sync_n;
   logic [CODE_W-1:0]           external_reference_in;
   logic [CH_N-1:0][CODE_W-1:0] dac_code, sub_code, bias_code;
   logic [CH_N-1:0]             bias_div16;
   int                          errors, num_checks;
   logic [CODE_W-1:0]           vals [CH_N] = '{10'h011, 10'h2a5, 10'h3ff, 10'h000};

   sdli_host_model sdli_host_model_i (.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
      .frame_sync_n(frame_sync_n));
   sdli_top sdli_top_i (.clk(clk), .rst_b(rst_b), .serial_clock_in(serial_clock_in),
      .serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n), .load_outputs_n(load_outputs_n),
      .async_clear_n(async_clear_n), .power_down_n(power_down_n), .external_reference_in(external_reference_in),
      .dac_code(dac_code), .sub_code(sub_code), .bias_code(bias_code), .bias_div16(bias_div16),
      .low_power(low_power));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk_code(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic [CH_N-1:0] got, input logic [CH_N-1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Word sent whole, then time for sync and decode to land
   task automatic snd(input logic [1:0] cmd, input logic [CH_AW-1:0] ch, input logic [CODE_W-1:0] v);
      sdli_host_model_i.send_word({cmd, ch, 2'h0, v}, 16, 1'b1);
      wait_clk(6);
   endtask

   task automatic results;
      $display("errors %0d checks %0d", errors, num_checks);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic test_reset;
      for (int c = 0; c < CH_N; c++)
      begin
         chk_code(dac_code[c], DAC_RST);
         chk_code(sub_code[c], SUB_RST);
         chk_code(bias_code[c], BIAS_INT_CODE);
      end
      chk_flag(bias_div16 | {3'h0, low_power}, 4'h0);
   endtask

   // Held strobe must keep outputs until it falls, then move all channels
   task automatic test_load;
      for (int c = 0; c < CH_N; c++)
         snd(CMD_DATA, CH_AW'(c), vals[c]);
      for (int c = 0; c < CH_N; c++)
         chk_code(dac_code[c], DAC_RST);
      load_outputs_n = 1'b0;
      wait_clk(5);
      for (int c = 0; c < CH_N; c++)
         chk_code(dac_code[c], vals[c]);
   endtask

   task automatic test_auto;
      snd(CMD_DATA, 2'h2, 10'h155);
      chk_code(dac_code[2], 10'h155);
      load_outputs_n = 1'b1;
   endtask

   // Short frame, unframed clocks and the unused command code must leave channel 1 alone
   task automatic test_partial;
      sdli_host_model_i.send_word({CMD_DATA, 2'h1, 2'h0, 10'h0aa}, 10, 1'b1);
      sdli_host_model_i.send_word({CMD_DATA, 2'h1, 2'h0, 10'h0bb}, 16, 1'b0);
      snd(2'h3, 2'h1, 10'h0cc);
      wait_clk(3);
      load_outputs_n = 1'b0;
      wait_clk(5);
      chk_code(dac_code[1], vals[1]);
      load_outputs_n = 1'b1;
   endtask

   task automatic test_clear;
      snd(CMD_CTRL, 2'h1, 10'h002);
      snd(CMD_SUB, 2'h2, 10'h123);
      chk_code(sub_code[2], 10'h123);
      async_clear_n = 1'b0;
      wait_clk(5);
      for (int c = 0; c < CH_N; c++)
      begin
         chk_code(dac_code[c], CODE_MID);
         chk_code(sub_code[c], SUB_RST);
      end
      chk_flag(bias_div16, 4'h2);
      async_clear_n = 1'b1;
      wait_clk(1);
      load_outputs_n = 1'b0;
      wait_clk(5);
      chk_code(dac_code[0], vals[0]);
      chk_flag(bias_div16, 4'h0);
      load_outputs_n = 1'b1;
   endtask

   task automatic test_power;
      power_down_n = 1'b0;
      wait_clk(5);
      chk_flag({3'h0, low_power}, 4'h1);
      power_down_n = 1'b1;
      wait_clk(5);
      chk_flag({3'h0, low_power}, 4'h0);
   endtask

   task automatic test_ref;
      snd(CMD_CTRL, 2'h3, 10'h001);
      chk_code(bias_code[3], 10'h16b);
      chk_code(bias_code[0], BIAS_INT_CODE);
   endtask

   initial
   begin
      #2000000;
      errors++;
      results();
   end

   initial
   begin
      rst_b                 = 1'b0;
      load_outputs_n        = 1'b1;
      async_clear_n         = 1'b1;
      power_down_n          = 1'b1;
      external_reference_in = 10'h16b;
      wait_clk(16);
      rst_b = 1'b1;
      wait_clk(3);
      test_reset();
      test_load();
      test_auto();
      test_partial();
      test_clear();
      test_power();
      test_ref();
      results();
   end
endmodule // sdli_top_tb
